// ---- core/l3_event_pkg.sv ----
// Shared constants for the bus-interface-unit event counter block
package l3_event_pkg;

  // Widths of a model register, its halves, the address and the counter read index
  localparam int unsigned WORD_W   = 64;
  localparam int unsigned HALF_W   = 32;
  localparam int unsigned ADDR_W   = 20;
  localparam int unsigned INDEX_W  = 8;

  // Model register addresses
  localparam logic [19:0] BUS_QUEUE_EVENT_0_ADDR     = 20'h107cc;
  localparam logic [19:0] BUS_QUEUE_EVENT_1_ADDR     = 20'h107cd;
  localparam logic [19:0] SNOOP_QUEUE_EVENT_0_ADDR   = 20'h107ce;
  localparam logic [19:0] SNOOP_QUEUE_EVENT_1_ADDR   = 20'h107cf;
  localparam logic [19:0] DATA_READY_EVENT_0_ADDR    = 20'h107d0;
  localparam logic [19:0] DATA_READY_EVENT_1_ADDR    = 20'h107d1;
  localparam logic [19:0] LATENCY_EVENT_CONTROL_ADDR = 20'h107d2;
  localparam logic [19:0] LATENCY_EVENT_COUNTER_ADDR = 20'h107d3;

  // Slot numbers inside the register block
  localparam int unsigned NUM_REGS      = 8;
  localparam int unsigned NUM_QUEUE     = 6;
  localparam logic [2:0]  LAT_CTRL_SLOT = 3'h6;
  localparam logic [2:0]  LAT_CNT_SLOT  = 3'h7;

  // Counter read instruction index range
  localparam logic [7:0] PMC_FIRST_INDEX = 8'h12;
  localparam logic [7:0] PMC_LAST_INDEX  = 8'h19;

  // Latency run bit in the latency control register
  localparam int unsigned LAT_ENABLE_BIT = 26;

  // Values after reset
  localparam logic [63:0] WORD_RESET = 64'h0;
  localparam logic [31:0] HALF_RESET = 32'h0;

endpackage : l3_event_pkg

// ---- core/event_counter_slice.sv ----
// One queue event register: control in the upper half, counter below
`timescale 1ns/1ps
module event_counter_slice #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_i,
  input  wire logic [63:0] wdata_i,
  input  wire logic        event_i,
  output logic      [63:0] value_o
);

  // Elaboration check on the counter width
  if (CNT_W != l3_event_pkg::HALF_W)
  begin : g_bad_width
    $error("event_counter_slice: counter must be 32 bits wide");
  end

  logic [31:0] ctrl;
  logic [31:0] count;
  logic [31:0] next_count;
  logic        enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Any set control bit starts counting, all zero freezes it
  assign enabled    = |ctrl;
  assign next_count = wr_i                ? wdata_i[31:0] :
                      (enabled && event_i) ? count + 32'h1 :
                      count;
  assign value_o    = {ctrl, count};

  // Control and counter halves
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl  <= l3_event_pkg::HALF_RESET;
      count <= l3_event_pkg::HALF_RESET;
    end
    else
    begin
      if (wr_i)
        ctrl <= wdata_i[63:32];
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_slice_frozen_hold : assert property (
    !wr_i && ctrl == 32'h0 |=> count == $past(count))
    else $error("Frozen counter moved");

  a_slice_count_step : assert property (
    !wr_i && ctrl != 32'h0 && event_i |=> count == $past(count) + 32'h1)
    else $error("Enabled counter missed an event");

  a_slice_write_load : assert property (
    wr_i |=> count == $past(wdata_i[31:0]) && ctrl == $past(wdata_i[63:32]))
    else $error("Register write not loaded");

  a_slice_resume_value : assert property (
    !wr_i && ctrl == 32'h0 ##1 wr_i && wdata_i[63:32] != 32'h0
      && wdata_i[31:0] == count |=> count == $past(count)
      ##1 ($past(wr_i) || count == $past(count) + 32'($past(event_i))))
    else $error("Counter did not resume from held value");

endmodule : event_counter_slice

// ---- core/l3_bus_event_counters.sv ----
// Event counters of the bus interface unit, with model register access
// Contract
// - Low 32 bits of the six queue registers act as 32-bit counters.
// - Counter read instruction reaches the low halves of all eight registers at indices 18 to 25.
// - Counter read instruction returns zero in the upper result half.
// - Bus queue registers: control in upper half, counter in lower half.
// - Queue counters start once any upper control bit is written nonzero.
// - All six queue counters freeze when the upper half is written zero.
// - Snoop queue registers: control in upper half, counter in lower half.
// - Data ready counters start after any upper qualification bit is set.
// - Latency logic accumulates weighted cycle counts of bus queue transactions.
// - Latency counter runs while control bit 26 is one, else freezes.
// - Latency is accumulated in a full 64-bit counter register.
// - Exactly four event types: bus queue, snoop queue, data ready, latency.
`timescale 1ns/1ps
module l3_bus_event_counters #(
  parameter int unsigned WEIGHT_W = 8
) (
  input  wire logic                CORE_CLK_I,
  input  wire logic                RST_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  input  wire logic [19:0]         REG_ADDR_I,
  input  wire logic [63:0]         REG_WDATA_I,
  output logic      [63:0]         REG_RDATA_O,
  output logic                     REG_RVALID_O,
  output logic                     REG_FAULT_O,
  input  wire logic                PMC_RD_I,
  input  wire logic [7:0]          PMC_INDEX_I,
  output logic      [63:0]         PMC_RDATA_O,
  output logic                     PMC_RVALID_O,
  output logic                     PMC_FAULT_O,
  input  wire logic [1:0]          BUS_QUEUE_EVENT_I,
  input  wire logic [1:0]          SNOOP_QUEUE_EVENT_I,
  input  wire logic [1:0]          DATA_READY_EVENT_I,
  input  wire logic [WEIGHT_W-1:0] LATENCY_WEIGHT_I
);

  // Elaboration check on the latency weight width
  if (WEIGHT_W < 1 || WEIGHT_W > l3_event_pkg::WORD_W)
  begin : g_bad_weight
    $error("l3_bus_event_counters: WEIGHT_W must be 1 to 64");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Model register address to {hit, slot}
  function automatic logic [3:0] decode_addr(input logic [19:0] addr);
    logic [19:0] rel;
    rel = addr - l3_event_pkg::BUS_QUEUE_EVENT_0_ADDR;
    decode_addr = {(addr >= l3_event_pkg::BUS_QUEUE_EVENT_0_ADDR &&
                    addr <= l3_event_pkg::LATENCY_EVENT_COUNTER_ADDR), rel[2:0]};
  endfunction : decode_addr

  // Counter read index to {hit, slot}, ascending with address
  function automatic logic [3:0] decode_index(input logic [7:0] idx);
    logic [7:0] rel;
    rel = idx - l3_event_pkg::PMC_FIRST_INDEX;
    decode_index = {(idx >= l3_event_pkg::PMC_FIRST_INDEX &&
                     idx <= l3_event_pkg::PMC_LAST_INDEX), rel[2:0]};
  endfunction : decode_index

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [63:0] reg_view [8];
  logic [5:0]  queue_event;
  logic [3:0]  addr_dec;
  logic [3:0]  index_dec;
  logic        addr_hit;
  logic [2:0]  addr_slot;
  logic        index_hit;
  logic [2:0]  index_slot;
  logic        reg_wr_hit;
  logic        lat_ctrl_wr;
  logic        lat_cnt_wr;
  logic        lat_run;
  logic [63:0] lat_weight;
  logic [63:0] lat_ctrl;
  logic [63:0] lat_cnt;
  logic [63:0] next_lat_cnt;
  logic [63:0] reg_sel;
  logic [63:0] pmc_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Address and index decode
  assign addr_dec   = decode_addr(REG_ADDR_I);
  assign addr_hit   = addr_dec[3];
  assign addr_slot  = addr_dec[2:0];
  assign index_dec  = decode_index(PMC_INDEX_I);
  assign index_hit  = index_dec[3];
  assign index_slot = index_dec[2:0];

  // Full 64-bit write strobes per slot
  assign reg_wr_hit  = REG_WR_I && addr_hit;
  assign lat_ctrl_wr = reg_wr_hit && addr_slot == l3_event_pkg::LAT_CTRL_SLOT;
  assign lat_cnt_wr  = reg_wr_hit && addr_slot == l3_event_pkg::LAT_CNT_SLOT;

  ////////////////////////////////////////////////////////////////////////////
  // Six queue event registers: two bus queue, two snoop, two data ready
  assign queue_event = {DATA_READY_EVENT_I, SNOOP_QUEUE_EVENT_I,
                        BUS_QUEUE_EVENT_I};

  for (genvar g = 0; g < l3_event_pkg::NUM_QUEUE; g++)
  begin : g_queue
    event_counter_slice #(
      .CNT_W   (l3_event_pkg::HALF_W)
    ) u_slice (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RST_I),
      .wr_i    (reg_wr_hit && addr_slot == 3'(g)),
      .wdata_i (REG_WDATA_I),
      .event_i (queue_event[g]),
      .value_o (reg_view[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency event: weighted cycles summed while the run bit is set
  assign lat_run      = lat_ctrl[l3_event_pkg::LAT_ENABLE_BIT];
  assign lat_weight   = 64'(LATENCY_WEIGHT_I);
  assign next_lat_cnt = lat_cnt_wr ? REG_WDATA_I :
                        lat_run    ? lat_cnt + lat_weight :
                        lat_cnt;

  // Latency control and counter registers
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      lat_ctrl <= l3_event_pkg::WORD_RESET;
      lat_cnt  <= l3_event_pkg::WORD_RESET;
    end
    else
    begin
      if (lat_ctrl_wr)
        lat_ctrl <= REG_WDATA_I;
      lat_cnt <= next_lat_cnt;
    end
  end

  assign reg_view[l3_event_pkg::LAT_CTRL_SLOT] = lat_ctrl;
  assign reg_view[l3_event_pkg::LAT_CNT_SLOT]  = lat_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection, unmapped reads give zero
  assign reg_sel = addr_hit ? reg_view[addr_slot] : l3_event_pkg::WORD_RESET;

  // Counter read: low half of the slot, upper half forced to zero
  assign pmc_sel = index_hit ? {l3_event_pkg::HALF_RESET,
                                reg_view[index_slot][31:0]}
                             : l3_event_pkg::WORD_RESET;

  // Model register read answer, one cycle after the request
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      REG_RDATA_O  <= l3_event_pkg::WORD_RESET;
      REG_RVALID_O <= 1'b0;
      REG_FAULT_O  <= 1'b0;
    end
    else
    begin
      REG_RDATA_O  <= REG_RD_I ? reg_sel : l3_event_pkg::WORD_RESET;
      REG_RVALID_O <= REG_RD_I;
      REG_FAULT_O  <= (REG_RD_I || REG_WR_I) && !addr_hit;
    end
  end

  // Counter read answer, one cycle after the request
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      PMC_RDATA_O  <= l3_event_pkg::WORD_RESET;
      PMC_RVALID_O <= 1'b0;
      PMC_FAULT_O  <= 1'b0;
    end
    else
    begin
      PMC_RDATA_O  <= PMC_RD_I ? pmc_sel : l3_event_pkg::WORD_RESET;
      PMC_RVALID_O <= PMC_RD_I;
      PMC_FAULT_O  <= PMC_RD_I && !index_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_pmc_upper_zero : assert property (
    PMC_RD_I |=> PMC_RVALID_O && PMC_RDATA_O[63:32] == 32'h0)
    else $error("Counter read upper half not zero");

  a_pmc_first_index : assert property (
    PMC_RD_I && PMC_INDEX_I == 8'h12
      |=> PMC_RDATA_O[31:0] == $past(g_queue[0].u_slice.count))
    else $error("Index 18 does not read the lowest register");

  a_pmc_last_index : assert property (
    PMC_RD_I && PMC_INDEX_I == 8'h19
      |=> PMC_RDATA_O[31:0] == $past(lat_cnt[31:0]) && !PMC_FAULT_O)
    else $error("Index 25 does not read the latency counter");

  a_pmc_out_of_range : assert property (
    PMC_RD_I && (PMC_INDEX_I < 8'h12 || PMC_INDEX_I > 8'h19)
      |=> PMC_FAULT_O && PMC_RDATA_O == 64'h0)
    else $error("Out of range index not refused");

  a_pmc_low_counter : assert property (
    PMC_RD_I && PMC_INDEX_I == 8'h14
      |=> PMC_RDATA_O[31:0] == $past(reg_view[2][31:0]))
    else $error("Index 20 does not read the snoop counter");

  a_lat_frozen_hold : assert property (
    !lat_ctrl[26] && !lat_cnt_wr && !lat_ctrl_wr [*2]
      |=> lat_cnt == $past(lat_cnt, 2))
    else $error("Latency counter moved while frozen");

  a_lat_weighted_sum : assert property (
    lat_ctrl[26] && !lat_cnt_wr
      |=> lat_cnt == $past(lat_cnt) + 64'($past(LATENCY_WEIGHT_I)))
    else $error("Latency counter did not add the weight");

  a_lat_full_width : assert property (
    lat_ctrl[26] && !lat_cnt_wr && lat_cnt[31:0] == 32'hffffffff
      && LATENCY_WEIGHT_I == 1 |=> lat_cnt[63:32] == $past(lat_cnt[63:32]) + 32'h1)
    else $error("Latency counter carry lost above bit 31");

  a_reg_readback : assert property (
    REG_WR_I && REG_ADDR_I == 20'h107cc ##1 REG_RD_I && REG_ADDR_I == 20'h107cc
      && !REG_WR_I |=> REG_RDATA_O[63:32] == $past(REG_WDATA_I[63:32], 2))
    else $error("Control half not read back");

  a_queue_start : assert property (
    REG_WR_I && REG_ADDR_I == 20'h107cd && REG_WDATA_I[63:32] != 32'h0
      && REG_WDATA_I[31:0] == 32'h0 ##1 !REG_WR_I && BUS_QUEUE_EVENT_I[1]
      |=> reg_view[1][31:0] == 32'h1)
    else $error("Bus queue counter did not start");

  a_unmapped_fault : assert property (
    REG_RD_I && (REG_ADDR_I < 20'h107cc || REG_ADDR_I > 20'h107d3)
      |=> REG_FAULT_O && REG_RVALID_O && REG_RDATA_O == 64'h0)
    else $error("Unmapped read not refused");

  // Quiet answers when nothing was asked, and a fault on unmapped writes
  a_reg_read_quiet : assert property (
    !REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 64'h0)
    else $error("Read answer without a read");

  a_pmc_read_quiet : assert property (
    !PMC_RD_I |=> !PMC_RVALID_O && !PMC_FAULT_O && PMC_RDATA_O == 64'h0)
    else $error("Counter read answer without a read");

  a_unmapped_write : assert property (
    REG_WR_I && (REG_ADDR_I < 20'h107cc || REG_ADDR_I > 20'h107d3) |=> REG_FAULT_O)
    else $error("Unmapped write not refused");

  // Latency control and counter access
  a_lat_ctrl_read : assert property (
    REG_RD_I && REG_ADDR_I == 20'h107d2 |=> REG_RVALID_O && REG_RDATA_O == $past(lat_ctrl))
    else $error("Latency control not read back");

  a_lat_ctrl_store : assert property (
    lat_ctrl_wr |=> lat_ctrl == $past(REG_WDATA_I))
    else $error("Latency control write not stored");

  a_lat_cnt_load : assert property (
    lat_cnt_wr |=> lat_cnt == $past(REG_WDATA_I))
    else $error("Latency counter write not loaded");

  // Counter read index map inside the range
  a_pmc_ctrl_index : assert property (
    PMC_RD_I && PMC_INDEX_I == 8'h18 |=> PMC_RDATA_O == {32'h0, $past(lat_ctrl[31:0])})
    else $error("Index 24 does not read the latency control low half");

  a_pmc_ready_index : assert property (
    PMC_RD_I && PMC_INDEX_I == 8'h16 |=> PMC_RDATA_O[31:0] == $past(reg_view[4][31:0]))
    else $error("Index 22 does not read the data ready counter");

  // Zero control half freezes a data ready counter
  a_ready_freeze : assert property (
    REG_WR_I && REG_ADDR_I == 20'h107d0 && REG_WDATA_I[63:32] == 32'h0
      |=> reg_view[4][63:32] == 32'h0
      ##1 ($past(REG_WR_I) || reg_view[4][31:0] == $past(reg_view[4][31:0])))
    else $error("Data ready counter moved after freeze");

  c_latency_running : cover property (
    lat_ctrl[26] && LATENCY_WEIGHT_I != 0 ##1 lat_cnt != 64'h0);

  c_queue_counting : cover property (
    queue_event[4] && reg_view[4][63:32] != 32'h0 ##1 reg_view[4][31:0] != 32'h0);

  c_pmc_read_all : cover property (
    PMC_RD_I && PMC_INDEX_I == 8'h12 ##[1:20] PMC_RD_I && PMC_INDEX_I == 8'h19);

  c_freeze_resume : cover property (
    lat_ctrl_wr && !REG_WDATA_I[26] ##[1:10] lat_ctrl_wr && REG_WDATA_I[26]);

endmodule : l3_bus_event_counters

// ---- testbench/core_access_model.sv ----
// Processor core model issuing model register accesses and counter reads
`timescale 1ns/1ps
module core_access_model (
  input  wire logic        clk_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [19:0] addr_o,
  output logic      [63:0] wdata_o,
  output logic             pmc_rd_o,
  output logic      [7:0]  index_o,
  input  wire logic [63:0] rdata_i,
  input  wire logic [63:0] pmc_rdata_i
);
  // Idle bus at time zero
  initial
  begin
    {wr_o, rd_o, pmc_rd_o} = 3'h0;
    addr_o = 20'h0;
    wdata_o = 64'h0;
    index_o = 8'h0;
  end

  // One request per falling edge, held across the next rising edge
  task automatic access(input logic w, input logic r, input logic [19:0] a,
                        input logic [63:0] d, input logic p, input logic [7:0] i);
    @(negedge clk_i);
    wr_o = w;
    rd_o = r;
    addr_o = a;
    wdata_o = d; // Always a whole 64-bit word
    pmc_rd_o = p;
    index_o = i;
  endtask : access

  // Read both ports, then release with inverted lines and take the answers
  task automatic fetch(input logic [19:0] a, input logic [7:0] i,
                       output logic [63:0] rv, output logic [63:0] pv);
    access(1'b0, 1'b1, a, 64'h0, 1'b1, i);
    access(1'b0, 1'b0, ~a, ~64'h0, 1'b0, ~i);
    rv = rdata_i;
    pv = pmc_rdata_i;
  endtask : fetch
endmodule : core_access_model

// ---- testbench/l3_bus_event_counters_tb.sv ----
// Self-checking bench of the bus interface unit event counters
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module l3_bus_event_counters_tb;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        wr, rd, prd, rvalid, rfault, pvalid, pfault, mapped, in_range;
  logic        e_rv, e_rf, e_pv, e_pf;
  logic [19:0] addr;
  logic [7:0]  idx;
  logic [63:0] wdata, rdata, pdata, rv, pv, e_rd, e_pd;
  logic [63:0] mdl [8];
  logic [1:0]  bq = 2'h0, sq = 2'h0, dr = 2'h0;
  logic [7:0]  wt = 8'h0;
  logic        ev_all = 1'b0;
  logic [5:0]  ev;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          slot;

  always #2 core_clk = ~core_clk;

  l3_bus_event_counters dut (.CORE_CLK_I(core_clk), .RST_I(rst), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .REG_FAULT_O(rfault), .PMC_RD_I(prd), .PMC_INDEX_I(idx),
    .PMC_RDATA_O(pdata), .PMC_RVALID_O(pvalid), .PMC_FAULT_O(pfault),
    .BUS_QUEUE_EVENT_I(bq), .SNOOP_QUEUE_EVENT_I(sq), .DATA_READY_EVENT_I(dr),
    .LATENCY_WEIGHT_I(wt));

  core_access_model core (.clk_i(core_clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .pmc_rd_o(prd), .index_o(idx), .rdata_i(rdata), .pmc_rdata_i(pdata));

  // Random events and latency weights
  always @(negedge core_clk)
  begin
    {dr, sq, bq} <= ev_all ? 6'h3f : 6'($urandom);
    wt <= ev_all ? 8'h1 : 8'($urandom);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model: answers taken at the request edge, then counting, write wins
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      foreach (mdl[k]) mdl[k] = 64'h0;
      {e_rv, e_rf, e_pv, e_pf, e_rd, e_pd} = '0;
    end
    else
    begin
      mapped = addr >= l3_event_pkg::BUS_QUEUE_EVENT_0_ADDR
            && addr <= l3_event_pkg::LATENCY_EVENT_COUNTER_ADDR;
      slot = int'(addr - l3_event_pkg::BUS_QUEUE_EVENT_0_ADDR);
      in_range = idx >= l3_event_pkg::PMC_FIRST_INDEX && idx <= l3_event_pkg::PMC_LAST_INDEX;
      e_rv = rd;
      e_rf = (rd | wr) & ~mapped;
      e_rd = (rd && mapped) ? mdl[slot[2:0]] : 64'h0;
      e_pv = prd;
      e_pf = prd & ~in_range;
      e_pd = 64'h0;
      if (prd && in_range)
        e_pd = {32'h0, mdl[3'(idx - l3_event_pkg::PMC_FIRST_INDEX)][31:0]};
      ev = {dr, sq, bq};
      for (int k = 0; k < 6; k++)
        if (mdl[k][63:32] != 32'h0 && ev[k])
          mdl[k][31:0] += 32'h1;
      if (mdl[6][l3_event_pkg::LAT_ENABLE_BIT])
        mdl[7] += 64'(wt);
      if (wr && mapped)
        mdl[slot[2:0]] = wdata;
    end
  end

  // Every answer compared with the model each cycle
  always @(negedge core_clk)
  if (!rst)
  begin
    `CHK("reg_rvalid", e_rv, rvalid)
    `CHK("reg_fault", e_rf, rfault)
    `CHK("reg_rdata", e_rd, rdata)
    `CHK("pmc_rvalid", e_pv, pvalid)
    `CHK("pmc_fault", e_pf, pfault)
    `CHK("pmc_rdata", e_pd, pdata)
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the expected run
  initial
  begin
    #20000;
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'h02d1));
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    // Reset values over the map and one place beyond each end
    for (int a = 'h107cb; a <= 'h107d4; a++)
    begin
      core.fetch(20'(a), 8'(a - 'h107ba), rv, pv);
      `CHK("pmc_upper", 32'h0, pv[63:32])
    end
    // Enable each queue counter near its wrap point, one control bit each
    for (int s = 0; s < 6; s++)
      core.access(1'b1, 1'b0, 20'h107cc + 20'(s), {32'h1 << (s * 5), 32'hffff_fff0},
                  1'b0, 8'h0);
    core.access(1'b1, 1'b0, 20'h107d3, 64'hffff_ffff_ffff_ff00, 1'b0, 8'h0);
    core.access(1'b1, 1'b0, 20'h107d2, 64'h1 << 26, 1'b0, 8'h0);
    // Back-to-back reads through both ports
    repeat (300)
      core.access(1'b0, 1'b1, 20'h107cc + 20'($urandom_range(7)), 64'h0, 1'b1,
                  8'($urandom_range(26, 17)));
    // Freeze every counter with a known value and see that it holds
    for (int s = 0; s < 8; s++)
      core.access(1'b1, 1'b0, 20'h107cc + 20'(s), 64'(s + 3), 1'b0, 8'h0);
    repeat (20) core.access(1'b0, 1'b0, 20'h0, 64'h0, 1'b0, 8'h0);
    for (int s = 0; s < 8; s++)
    begin
      core.fetch(20'h107cc + 20'(s), 8'h12 + 8'(s), rv, pv);
      `CHK("frozen", 64'(s + 3), rv)
    end
    // Resume each queue counter from its held value, every event high, weight one
    ev_all = 1'b1;
    for (int s = 0; s < 6; s++)
      core.access(1'b1, 1'b0, 20'h107cc + 20'(s), {32'h1, 32'(s + 3)},
                  1'b0, 8'h0);
    // Bus queue control halves read back, counter still zero in the read just after the write
    for (int n = 0; n < 4; n++)
    begin
      core.access(1'b1, 1'b0, 20'h107cc + 20'(n % 2), {32'h5, 32'h0}, 1'b0, 8'h0);
      core.fetch(20'h107cc + 20'(n % 2), 8'h12 + 8'(n % 2), rv, pv);
      `CHK("ctrl_readback", 64'h0000_0005_0000_0000, rv)
    end
    // Latency carry out of the low half
    core.access(1'b1, 1'b0, 20'h107d3, 64'h0000_0000_ffff_fffd, 1'b0, 8'h0);
    core.access(1'b1, 1'b0, 20'h107d2, 64'h1 << 26, 1'b0, 8'h0);
    repeat (4) core.access(1'b0, 1'b0, 20'h0, 64'h0, 1'b0, 8'h0);
    core.fetch(20'h107d3, 8'h19, rv, pv);
    `CHK("lat_carry", 32'h1, rv[63:32])
    ev_all = 1'b0;
    // Random mixed traffic, including unmapped places and zero control halves
    repeat (400)
      core.access(1'($urandom), 1'($urandom), 20'h107cb + 20'($urandom_range(9)),
                  {($urandom_range(3) == 0) ? 32'h0 : $urandom, $urandom}, 1'($urandom),
                  8'($urandom_range(26, 17)));
    core.access(1'b0, 1'b0, 20'h0, 64'h0, 1'b0, 8'h0);
    repeat (2) @(negedge core_clk);
    give_verdict();
  end
endmodule : l3_bus_event_counters_tb
